// [inc/dll_clock_control_params.svh]
// Register offsets, field positions, reset values for the loop clock control.
// Assumes 16-bit registers on a 12-bit word address space.
`ifndef DLL_CLOCK_CONTROL_PARAMS_SVH
`define DLL_CLOCK_CONTROL_PARAMS_SVH

// ****************************************
// Offsets
// ****************************************
`define OFS_LOOP_CTRL_STATUS 12'hA87
`define OFS_LOOP_TRIM_VALUES 12'hA88
`define OFS_LOOP_CLKSEL_TEN 12'hA89

// ****************************************
// Control and status fields
// ****************************************
`define POS_LOOP_BANDWIDTH 15
`define POS_OUT_CLK_INVERT 14
`define POS_CHARGE_CUR_HI 13
`define POS_CHARGE_CUR_LO 12
`define POS_PHASE_ADJ_HI 11
`define POS_PHASE_ADJ_LO 8
`define POS_POWER_OFF 7
`define POS_TRIM_SOURCE 6
`define POS_EXT_REF 5
`define POS_MONITOR_SEL 4
`define POS_FREQ_RANGE_HI 3
`define POS_FREQ_RANGE_LO 2
`define POS_DIFF_DRV_CUR 1
`define POS_LOCK 0
`define RST_CTRL_STATUS 16'h0080

// ****************************************
// Trim and clock select fields
// ****************************************
`define POS_BANDGAP_HI 15
`define POS_BANDGAP_LO 13
`define POS_CORE_BIAS_HI 12
`define POS_CORE_BIAS_LO 11
`define POS_SOURCE_BIAS_HI 10
`define POS_SOURCE_BIAS_LO 8
`define RST_TRIM_HIGH 8'h00
`define POS_CLK_SOURCE 15
`define POS_TEN_HI 13
`define POS_TEN_LO 11
`define RST_CLKSEL_TEN 16'h0000
`define TRIM_ENABLE_KEY 3'h5

// ****************************************
// Loop integrator
// ****************************************
`define INTEG_MIDSCALE 16'h8000
`define INTEG_STEP_NORMAL 16'h0001
`define INTEG_STEP_HIGH 16'h0010

`endif

// [inc/dll_clock_control_pkg.sv]
// Types shared by the loop clock control and its integrator.
// Assumes the params header is included by the design files.
package dll_clock_control_pkg;

    typedef enum logic [0:0] {
        TRIM_FROM_FUSE = 1'b0,
        TRIM_FROM_SERIAL = 1'b1
    } trim_src_t;

    typedef enum logic [0:0] {
        BW_NORMAL = 1'b0,
        BW_HIGH = 1'b1
    } loop_bw_t;

endpackage

// [logic/loop_integrator.sv]
// Digital loop integrator steering the delay line code.
// Assumes phase up/down pulses are already in the mclk domain.
`include "dll_clock_control_params.svh"

module loop_integrator
    import dll_clock_control_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic loopRun,
    input wire loop_bw_t bwSel,
    input wire logic phaseUp,
    input wire logic phaseDn,
    output logic [7:0] delayCode
);

    logic [15:0] acc_q;
    logic [15:0] step;

    // 12-bit integrator is the 16-bit one with the low four bits skipped
    assign step = (bwSel == BW_HIGH) ? `INTEG_STEP_HIGH : `INTEG_STEP_NORMAL;

    // ****************************************
    // Accumulator
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_q <= `INTEG_MIDSCALE;
        end
        else if (!loopRun)
        begin
            acc_q <= `INTEG_MIDSCALE;
        end
        else if (phaseUp && !phaseDn && (acc_q <= 16'hFFFF - step))
        begin
            acc_q <= acc_q + step;
        end
        else if (phaseDn && !phaseUp && (acc_q >= step))
        begin
            acc_q <= acc_q - step;
        end
    end

    assign delayCode = acc_q[15:8];

    // ****************************************
    // Checks
    // ****************************************
    // Checked on the accumulator: the code byte moves only every 16 or 256 steps
    chk_high_bw_step: assert property (@(posedge mclk) disable iff (!reset_n)
        (loopRun && bwSel == BW_HIGH && phaseUp && !phaseDn && acc_q <= 16'hFFEF)
            |=> acc_q == $past(acc_q) + 16'h0010)
        else $error("high bandwidth step is not sixteen");

    chk_normal_bw_step: assert property (@(posedge mclk) disable iff (!reset_n)
        (loopRun && bwSel == BW_NORMAL && phaseUp && !phaseDn && acc_q != 16'hFFFF)
            |=> acc_q == $past(acc_q) + 16'h0001)
        else $error("normal bandwidth step is not one");

endmodule

// [logic/dll_clock_control.sv]
// Loop clock control: register file, trim source choice, lock status.
// Assumes a serial-port decoder drives the register strobes on mclk;
// lock, fuse and phase detector signals arrive asynchronously.
`include "dll_clock_control_params.svh"

module dll_clock_control
    import dll_clock_control_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [11:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    output logic regRdValid,
    input wire logic loopLockedRaw,
    input wire logic [7:0] fuseTrimRaw,
    input wire logic phaseUpRaw,
    input wire logic phaseDnRaw,
    output logic loopPowerDown,
    output logic datapathUsesRawClock,
    output logic loopLocked,
    output logic [7:0] delayCode,
    output logic [7:0] appliedTrim,
    output logic [2:0] bandgapTrim,
    output logic [1:0] coreBiasTrim,
    output logic [2:0] sourceBiasTrim,
    output logic [7:0] loopCtrlBits
);

    // ****************************************
    // Registers and synchronisers
    // ****************************************
    logic [15:0] ctrl_q;
    logic [7:0] trimHigh_q;
    logic [15:0] clkSel_q;
    logic lockMeta_q, lockSync_q;
    logic [7:0] fuseMeta_q, fuseSync_q;
    logic upMeta_q, upSync_q, dnMeta_q, dnSync_q;
    logic [15:0] rdData_q;
    logic rdValid_q;
    logic loopDown_q, rawClk_q, locked_q;
    logic [7:0] applied_q;
    logic [7:0] loopBits_q;
    logic [15:0] statusWord;
    logic [15:0] trimWord;
    logic serialTrimOk;
    trim_src_t trimSrc;
    logic [7:0] integCode;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lockMeta_q <= 1'b0;
            lockSync_q <= 1'b0;
            fuseMeta_q <= 8'h00;
            fuseSync_q <= 8'h00;
            upMeta_q <= 1'b0;
            upSync_q <= 1'b0;
            dnMeta_q <= 1'b0;
            dnSync_q <= 1'b0;
        end
        else
        begin
            lockMeta_q <= loopLockedRaw;
            lockSync_q <= lockMeta_q;
            fuseMeta_q <= fuseTrimRaw;
            fuseSync_q <= fuseMeta_q;
            upMeta_q <= phaseUpRaw;
            upSync_q <= upMeta_q;
            dnMeta_q <= phaseDnRaw;
            dnSync_q <= dnMeta_q;
        end
    end

    // ****************************************
    // Writable registers
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= `RST_CTRL_STATUS;
        end
        else if (regWrite && regAddr == `OFS_LOOP_CTRL_STATUS)
        begin
            ctrl_q <= regWrData;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trimHigh_q <= `RST_TRIM_HIGH;
        end
        else if (regWrite && regAddr == `OFS_LOOP_TRIM_VALUES)
        begin
            trimHigh_q <= regWrData[15:8];
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clkSel_q <= `RST_CLKSEL_TEN;
        end
        else if (regWrite && regAddr == `OFS_LOOP_CLKSEL_TEN)
        begin
            clkSel_q <= regWrData & 16'hB800;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Lock bit is read-only; write data in its place is dropped
    assign statusWord = {ctrl_q[15:1], lockSync_q};
    // Low byte always shows fuses, so it tracks them from reset on
    assign trimWord = {trimHigh_q, fuseSync_q};

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdData_q <= 16'h0000;
            rdValid_q <= 1'b0;
        end
        else
        begin
            rdValid_q <= regRead;
            if (regRead)
            begin
                unique case (regAddr)
                    `OFS_LOOP_CTRL_STATUS: rdData_q <= statusWord;
                    `OFS_LOOP_TRIM_VALUES: rdData_q <= trimWord;
                    `OFS_LOOP_CLKSEL_TEN: rdData_q <= clkSel_q;
                    default: rdData_q <= 16'h0000;
                endcase
            end
        end
    end

    // ****************************************
    // Trim source and clock control
    // ****************************************
    assign trimSrc = trim_src_t'(ctrl_q[`POS_TRIM_SOURCE]);
    assign serialTrimOk = (trimSrc == TRIM_FROM_SERIAL) &&
        (clkSel_q[`POS_TEN_HI:`POS_TEN_LO] == `TRIM_ENABLE_KEY);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            applied_q <= 8'h00;
            loopDown_q <= 1'b1;
            rawClk_q <= 1'b0;
            locked_q <= 1'b0;
            loopBits_q <= 8'h00;
        end
        else
        begin
            // Fuse value wins unless serial source is selected and the test key is present
            applied_q <= serialTrimOk ? trimHigh_q : fuseSync_q;
            loopDown_q <= ctrl_q[`POS_POWER_OFF];
            rawClk_q <= clkSel_q[`POS_CLK_SOURCE];
            locked_q <= lockSync_q;
            loopBits_q <= ctrl_q[15:8];
        end
    end

    loop_integrator integ (
        .mclk(mclk),
        .reset_n(reset_n),
        .loopRun(!loopDown_q),
        .bwSel(loop_bw_t'(ctrl_q[`POS_LOOP_BANDWIDTH])),
        .phaseUp(upSync_q),
        .phaseDn(dnSync_q),
        .delayCode(integCode)
    );

    assign regRdData = rdData_q;
    assign regRdValid = rdValid_q;
    assign loopPowerDown = loopDown_q;
    assign datapathUsesRawClock = rawClk_q;
    assign loopLocked = locked_q;
    assign delayCode = integCode;
    assign appliedTrim = applied_q;
    assign bandgapTrim = applied_q[7:5];
    assign coreBiasTrim = applied_q[4:3];
    assign sourceBiasTrim = applied_q[2:0];
    assign loopCtrlBits = loopBits_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_power_off_follow: assert property (
        (regWrite && regAddr == `OFS_LOOP_CTRL_STATUS)
            |=> ##1 (loopPowerDown == $past(regWrData[`POS_POWER_OFF], 2)))
        else $error("power-down output does not follow control write");

    chk_off_holds_code: assert property (
        loopPowerDown [*3] |-> delayCode == 8'h80)
        else $error("integrator not held while loop is off");

    chk_lock_readback: assert property (
        (regRead && regAddr == `OFS_LOOP_CTRL_STATUS)
            |=> regRdValid && regRdData[`POS_LOCK] == $past(lockSync_q))
        else $error("lock status bit mismatch on read");

    chk_fuse_default: assert property (
        (ctrl_q[`POS_TRIM_SOURCE] == 1'b0) ##1 (ctrl_q[`POS_TRIM_SOURCE] == 1'b0)
            |-> appliedTrim == $past(fuseSync_q))
        else $error("fuse trim not applied with fuse source");

    chk_fuse_readback: assert property (
        (regRead && regAddr == `OFS_LOOP_TRIM_VALUES)
            |=> regRdData[7:0] == $past(fuseSync_q))
        else $error("fuse field does not read programmed bits");

    chk_clock_source: assert property (
        (regWrite && regAddr == `OFS_LOOP_CLKSEL_TEN)
            |=> ##1 datapathUsesRawClock == $past(regWrData[`POS_CLK_SOURCE], 2))
        else $error("clock source output does not follow write");

    chk_trim_key: assert property (
        (appliedTrim != $past(fuseSync_q)) |->
            $past(clkSel_q[`POS_TEN_HI:`POS_TEN_LO]) == 3'h5
            && $past(ctrl_q[`POS_TRIM_SOURCE]))
        else $error("serial trim applied without trim-enable key");

    chk_trim_store: assert property (
        (regWrite && regAddr == `OFS_LOOP_TRIM_VALUES)
            |=> trimHigh_q == $past(regWrData[15:8]))
        else $error("trim fields not stored");

    cov_serial_trim: cover property (serialTrimOk ##1 appliedTrim == trimHigh_q);
    cov_loop_on: cover property ($fell(loopPowerDown));
    cov_lock_rise: cover property ($rose(loopLocked));
    cov_raw_clock: cover property ($rose(datapathUsesRawClock));

endmodule

// [bench/test_dll_clock_control.sv]
// Self-checking bench for the loop clock control register block.
// Assumes the params header and package are compiled first; no partner model.
`include "dll_clock_control_params.svh"

module test_dll_clock_control
    import dll_clock_control_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, reset_n, regWrite, regRead, loopLockedRaw, phaseUpRaw, phaseDnRaw;
    logic [11:0] regAddr;
    logic [15:0] regWrData, regRdData, rd;
    logic regRdValid, loopPowerDown, datapathUsesRawClock, loopLocked;
    logic [7:0] fuseTrimRaw, delayCode, appliedTrim, loopCtrlBits;
    logic [2:0] bandgapTrim, sourceBiasTrim;
    logic [1:0] coreBiasTrim;
    int error_cnt, compares;

    dll_clock_control dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .regRdValid(regRdValid), .loopLockedRaw(loopLockedRaw),
        .fuseTrimRaw(fuseTrimRaw), .phaseUpRaw(phaseUpRaw), .phaseDnRaw(phaseDnRaw),
        .loopPowerDown(loopPowerDown), .datapathUsesRawClock(datapathUsesRawClock),
        .loopLocked(loopLocked), .delayCode(delayCode), .appliedTrim(appliedTrim),
        .bandgapTrim(bandgapTrim), .coreBiasTrim(coreBiasTrim),
        .sourceBiasTrim(sourceBiasTrim), .loopCtrlBits(loopCtrlBits));

    // ****************************************
    // Clock and helpers
    // ****************************************
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(negedge mclk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge mclk);
        regWrite = 1'b0;
        // Control outputs need store plus output flop
        repeat (3) @(negedge mclk);
    endtask

    // Valid is sampled one cycle after the strobe edge
    task automatic rdreg(input logic [11:0] a);
        @(negedge mclk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge mclk);
        regRead = 1'b0;
        check({15'h0000, regRdValid}, 16'h0001);
        rd = regRdData;
    endtask

    task automatic give_verdict();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Whole run is about six hundred cycles
    initial
    begin
        #200000;
        error_cnt++;
        give_verdict();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        reset_n = 1'b0;
        {regWrite, regRead, loopLockedRaw, phaseUpRaw, phaseDnRaw} = 5'h00;
        regAddr = 12'h000;
        regWrData = 16'h0000;
        fuseTrimRaw = 8'h3C;
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        check({15'h0000, loopPowerDown}, 16'h0001);
        check({15'h0000, datapathUsesRawClock}, 16'h0000);
        check({8'h00, appliedTrim}, 16'h003C);
        rdreg(`OFS_LOOP_CTRL_STATUS);
        check(rd, `RST_CTRL_STATUS);
        rdreg(`OFS_LOOP_CLKSEL_TEN);
        check(rd, `RST_CLKSEL_TEN);
        rdreg(`OFS_LOOP_TRIM_VALUES);
        check(rd, 16'h003C);
        rdreg(12'h000);
        check(rd, 16'h0000);
        wr(12'h000, 16'hFFFF);
        check({8'h00, appliedTrim}, 16'h003C);
        // Live fuse bits, not a reset constant
        fuseTrimRaw = 8'hC3;
        repeat (4) @(negedge mclk);
        rdreg(`OFS_LOOP_TRIM_VALUES);
        check(rd, 16'h00C3);
        // Lock reporting
        loopLockedRaw = 1'b1;
        repeat (4) @(negedge mclk);
        check({15'h0000, loopLocked}, 16'h0001);
        rdreg(`OFS_LOOP_CTRL_STATUS);
        check(rd, 16'h0081);
        loopLockedRaw = 1'b0;
        repeat (4) @(negedge mclk);
        rdreg(`OFS_LOOP_CTRL_STATUS);
        check(rd, 16'h0080);
        // Clock select and trim-enable readback
        wr(`OFS_LOOP_CLKSEL_TEN, 16'hFFFF);
        check({15'h0000, datapathUsesRawClock}, 16'h0001);
        rdreg(`OFS_LOOP_CLKSEL_TEN);
        check(rd, 16'hB800);
        // Trim source gating: key only counts with serial source
        wr(`OFS_LOOP_TRIM_VALUES, 16'hB6FF);
        rdreg(`OFS_LOOP_TRIM_VALUES);
        check(rd, 16'hB6C3);
        wr(`OFS_LOOP_CLKSEL_TEN, 16'h2800);
        check({15'h0000, datapathUsesRawClock}, 16'h0000);
        check({8'h00, appliedTrim}, 16'h00C3);
        wr(`OFS_LOOP_CTRL_STATUS, 16'h0040);
        check({15'h0000, loopPowerDown}, 16'h0000);
        check({8'h00, appliedTrim}, 16'h00B6);
        check({8'h00, bandgapTrim, coreBiasTrim, sourceBiasTrim}, 16'h00B6);
        wr(`OFS_LOOP_CLKSEL_TEN, 16'h2000);
        check({8'h00, appliedTrim}, 16'h00C3);
        // Integrator: 300 normal up steps, then 160 high up and 32 high down
        wr(`OFS_LOOP_CTRL_STATUS, 16'h0000);
        phaseUpRaw = 1'b1;
        repeat (300) @(negedge mclk);
        phaseUpRaw = 1'b0;
        repeat (6) @(negedge mclk);
        check({8'h00, delayCode}, 16'h0081);
        wr(`OFS_LOOP_CTRL_STATUS, 16'h0080);
        check({8'h00, delayCode}, 16'h0080);
        wr(`OFS_LOOP_CTRL_STATUS, 16'h8000);
        check({8'h00, loopCtrlBits}, 16'h0080);
        phaseUpRaw = 1'b1;
        repeat (160) @(negedge mclk);
        phaseUpRaw = 1'b0;
        repeat (6) @(negedge mclk);
        check({8'h00, delayCode}, 16'h008A);
        phaseDnRaw = 1'b1;
        repeat (32) @(negedge mclk);
        phaseDnRaw = 1'b0;
        repeat (6) @(negedge mclk);
        check({8'h00, delayCode}, 16'h0088);
        // Switching off from a moved code must pull it back to midscale
        wr(`OFS_LOOP_CTRL_STATUS, 16'h8080);
        check({15'h0000, loopPowerDown}, 16'h0001);
        check({8'h00, delayCode}, 16'h0080);
        give_verdict();
    end
endmodule
